//--- sppf_filter.v
// speech pre-emphasis / de-emphasis arithmetic datapath
`timescale 1ns/1ps
`default_nettype none
`include "sppf_consts.vh"
// Functional notes
// - de-emphasis: sr plus beta times previous output
// - only 16-bit and 32-bit signed operands
// - use 13 valid sample bits only
// - shifts arithmetic; negative count reverses direction
// - 16-bit add/sub saturate
// - truncating fractional product, min*min gives max
// - rounding product adds 16384 first
// - absolute value saturates at 32767
// - fractional division, equal operands give 32767
// - widening product is product shifted left one
// - 32-bit add/sub saturate
// - normalise shift count for 32-bit values
// - sign-extend to 32, truncate to 16
// - 160-sample frames, four 40-sample sub-segments
// - area ratios per frame, rest per sub-segment
// - downscale: right shift three, left two
// - high-pass difference shifted into 32-bit accumulator
// - recursive state split, 32735 scaling, rounded out
// - high-pass state persists, resets to zero
// - pre-emphasis with -28180 rounding product
module sppf_filter (
  input  wire        clk,
  input  wire        resetn,
  input  wire        enc_valid,
  input  wire [15:0] enc_sample,
  output wire        enc_ready,
  output reg         pre_valid,
  output reg  [15:0] pre_sample,
  output reg         pre_frame_start,
  output reg         pre_sub_start,
  input  wire        pre_ready,
  input  wire        dec_valid,
  input  wire [15:0] dec_sample,
  output reg         dec_ready,
  output reg         deemph_valid,
  output reg  [15:0] deemph_output,
  input  wire        deemph_ready,
  input  wire [15:0] norm_in,
  output reg  [5:0]  norm_count,
  input  wire [15:0] div_num,
  input  wire [15:0] div_den,
  output reg  [15:0] div_quot
);

  // saturating 16-bit add on 17-bit sum
  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15])
        sat_add = s[16] ? `SPPF_MIN16 : `SPPF_MAX16;
      else
        sat_add = s[15:0];
    end
  endfunction

  // saturating 16-bit subtract
  function [15:0] sat_sub;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {a[15], a} - {b[15], b};
      if (s[16] != s[15])
        sat_sub = s[16] ? `SPPF_MIN16 : `SPPF_MAX16;
      else
        sat_sub = s[15:0];
    end
  endfunction

  // saturating 32-bit add
  function [31:0] lsat_add;
    input [31:0] a;
    input [31:0] b;
    reg   [32:0] s;
    begin
      s = {a[31], a} + {b[31], b};
      if (s[32] != s[31])
        lsat_add = s[32] ? `SPPF_MIN32 : `SPPF_MAX32;
      else
        lsat_add = s[31:0];
    end
  endfunction

  // saturating 32-bit subtract
  function [31:0] lsat_sub;
    input [31:0] a;
    input [31:0] b;
    reg   [32:0] s;
    begin
      s = {a[31], a} - {b[31], b};
      if (s[32] != s[31])
        lsat_sub = s[32] ? `SPPF_MIN32 : `SPPF_MAX32;
      else
        lsat_sub = s[31:0];
    end
  endfunction

  // widening product, doubled; min*min never reaches it
  function [31:0] l_mult;
    input [15:0] a;
    input [15:0] b;
    reg signed [31:0] p;
    begin
      p = $signed(a) * $signed(b);
      l_mult = {p[30:0], 1'b0};
    end
  endfunction

  // rounding fractional product
  function [15:0] mult_rnd;
    input [15:0] a;
    input [15:0] b;
    reg signed [31:0] p;
    begin
      p = ($signed(a) * $signed(b)) + $signed(`SPPF_RND15);
      if (a == `SPPF_MIN16 && b == `SPPF_MIN16)
        mult_rnd = `SPPF_MAX16;
      else
        mult_rnd = p[30:15];
    end
  endfunction

  // count of left shifts to normalise a 32-bit word
  function [5:0] norm32;
    input [31:0] v;
    integer      i;
    reg          done;
    begin
      norm32 = 6'h00;
      done = 1'b0;
      if (v == 32'h00000000)
        done = 1'b1;
      if (v == 32'hc0000000)      // upper negative bound is already normal
        done = 1'b1;
      for (i = 30; i >= 0; i = i - 1) begin
        if (!done && v[i] == v[31])
          norm32 = norm32 + 6'h01;
        else
          done = 1'b1;
      end
    end
  endfunction

  // fractional division, restoring, fifteen quotient bits
  function [15:0] frac_div;
    input [15:0] n;
    input [15:0] d;
    integer      i;
    reg   [16:0] r;
    begin
      frac_div = 16'h0000;
      r = {1'b0, n};
      if (n == d)
        frac_div = `SPPF_MAX16;
      else begin
        for (i = 0; i < 15; i = i + 1) begin
          r = {r[15:0], 1'b0};
          frac_div = {frac_div[14:0], 1'b0};
          if (r >= {1'b0, d}) begin
            r = r - {1'b0, d};
            frac_div = frac_div | 16'h0001;
          end
        end
      end
    end
  endfunction

  // 16-bit shift left by a signed count; negative shifts right
  function [15:0] shl16;
    input [15:0] v;
    input [4:0]  n;               // two's complement count
    begin
      if (n[4])
        shl16 = $signed(v) >>> (~n + 5'h01);
      else
        shl16 = v << n;
    end
  endfunction

  // 32-bit shift left by a signed count; negative shifts right
  function [31:0] lshl32;
    input [31:0] v;
    input [5:0]  n;               // two's complement count
    begin
      if (n[5])
        lshl32 = $signed(v) >>> (~n + 6'h01);
      else
        lshl32 = v << n;
    end
  endfunction

  // truncating fractional product; not called by any stage in this module
  function [15:0] mult_trn;
    input [15:0] a;
    input [15:0] b;
    reg signed [31:0] p;
    begin
      p = $signed(a) * $signed(b);
      if (a == `SPPF_MIN16 && b == `SPPF_MIN16)
        mult_trn = `SPPF_MAX16;
      else
        mult_trn = p[30:15];
    end
  endfunction

  // magnitude; the most negative word would overflow, so clamp
  function [15:0] abs16;
    input [15:0] a;
    begin
      if (a == `SPPF_MIN16)
        abs16 = `SPPF_MAX16;
      else if (a[15])
        abs16 = 16'h0000 - a;
      else
        abs16 = a;
    end
  endfunction

  // ---------------- encoder input skid buffer (two entries)
  reg  [15:0] ebuf_q [0:1];       // buffered input words
  reg  [1:0]  ecnt_q;             // occupancy
  reg         ewr_q;              // write slot
  reg         erd_q;              // read slot
  wire        e_push = enc_valid && (ecnt_q != 2'h2);
  wire        e_avail = (ecnt_q != 2'h0);
  wire        o_free = !pre_valid || pre_ready;
  wire        e_pop = e_avail && o_free;
  wire [1:0]  ecnt_d = ecnt_q + {1'b0, e_push} - {1'b0, e_pop}; // next count
  reg         enc_rdy_q;          // registered back-pressure, tracks ecnt_q
  assign enc_ready = enc_rdy_q;   // back-pressure to source

  // filter state, persistent across frames
  reg  [15:0] hp_prev_input;      // previous downscaled sample
  reg  [31:0] hp_recursive_state; // 32-bit recursive state
  reg  [15:0] preemph_prev_sample;// previous offset-free sample
  reg  [7:0]  frm_cnt_q;          // position in 160-sample frame
  reg  [5:0]  sub_cnt_q;          // position in 40-sample segment

  // combinational encoder arithmetic
  reg  [15:0] so_w, s1_w, lsp_w, tmp_w, sof_w;
  reg  [31:0] ls2_w, z2_w, msp32_w, rnd_w;
  reg  [15:0] msp_w;
  always @* begin
    // low 3 bits dropped by the shift, the 13 valid bits remain
    so_w = shl16(ebuf_q[erd_q], `SPPF_DS_DOWN);
    so_w = shl16(so_w, `SPPF_DS_UP);
    s1_w = sat_sub(so_w, hp_prev_input);
    ls2_w = lshl32({{16{s1_w[15]}}, s1_w}, `SPPF_FRAC_UP);
    msp32_w = lshl32(hp_recursive_state, `SPPF_FRAC_DN);
    msp_w = msp32_w[15:0];
    z2_w = lsat_sub(hp_recursive_state, msp32_w << `SPPF_FRAC_SH);
    lsp_w = z2_w[15:0];
    tmp_w = mult_rnd(lsp_w, `SPPF_HP_COEF);
    ls2_w = lsat_add(ls2_w, {{16{tmp_w[15]}}, tmp_w});
    z2_w = lsat_add($signed(l_mult(msp_w, `SPPF_HP_COEF)) >>> 1,
                    ls2_w);
    rnd_w = lsat_add(z2_w, `SPPF_RND15);
    rnd_w = $signed(rnd_w) >>> `SPPF_FRAC_SH;
    sof_w = rnd_w[15:0];
  end

  // encoder side state update
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ecnt_q              <= 2'h0;
      enc_rdy_q           <= 1'b1;
      ewr_q               <= 1'b0;
      erd_q               <= 1'b0;
      ebuf_q[0]           <= 16'h0000;
      ebuf_q[1]           <= 16'h0000;
      hp_prev_input       <= 16'h0000;
      hp_recursive_state  <= 32'h00000000;
      preemph_prev_sample <= 16'h0000;
      frm_cnt_q           <= 8'h00;
      sub_cnt_q           <= 6'h00;
      pre_valid           <= 1'b0;
      pre_sample          <= 16'h0000;
      pre_frame_start     <= 1'b0;
      pre_sub_start       <= 1'b0;
    end else begin
      // buffer bookkeeping
      if (e_push) begin
        ebuf_q[ewr_q] <= enc_sample;
        ewr_q <= !ewr_q;
      end
      if (e_pop)
        erd_q <= !erd_q;
      ecnt_q <= ecnt_d;
      enc_rdy_q <= (ecnt_d != 2'h2);
      // markers only mean something alongside a valid word
      if (pre_valid && pre_ready) begin
        pre_valid       <= 1'b0;
        pre_frame_start <= 1'b0;
        pre_sub_start   <= 1'b0;
      end
      // one sample through the filters
      if (e_pop) begin
        hp_prev_input      <= so_w;
        hp_recursive_state <= z2_w;
        preemph_prev_sample <= sof_w;
        pre_sample <= sat_add(sof_w,
          mult_rnd(preemph_prev_sample, `SPPF_PRE_COEF));
        pre_valid <= 1'b1;
        // frame cadence markers for analysis stages
        pre_frame_start <= (frm_cnt_q == 8'h00);
        pre_sub_start   <= (sub_cnt_q == 6'h00);
        frm_cnt_q <= (frm_cnt_q == `SPPF_FRAME_LEN - 8'h01) ?
                     8'h00 : frm_cnt_q + 8'h01;
        sub_cnt_q <= (sub_cnt_q == `SPPF_SUB_LEN - 6'h01) ?
                     6'h00 : sub_cnt_q + 6'h01;
      end
    end
  end

  // ---------------- decoder de-emphasis post-filter
  reg  [15:0] deemph_prev_q;      // previous de-emphasis output
  wire        d_free = !deemph_valid || deemph_ready;
  wire [15:0] de_w = sat_add(dec_sample,
                     mult_rnd(deemph_prev_q, `SPPF_DE_COEF));

  // one-entry output holding, ready registered ahead
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deemph_prev_q <= 16'h0000;
      deemph_valid  <= 1'b0;
      deemph_output <= 16'h0000;
      dec_ready     <= 1'b0;
    end else begin
      dec_ready <= d_free && !(dec_valid && dec_ready);
      if (deemph_valid && deemph_ready)
        deemph_valid <= 1'b0;
      if (dec_valid && dec_ready) begin
        deemph_prev_q <= de_w;
        deemph_output <= de_w;
        deemph_valid  <= 1'b1;
      end
    end
  end

  // ---------------- exported primitive results
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      norm_count <= 6'h00;
      div_quot   <= 16'h0000;
    end else begin
      norm_count <= norm32({norm_in, 16'h0000});
      div_quot   <= frac_div(div_num, div_den);
    end
  end

endmodule // sppf_filter
`default_nettype wire

//--- sppf_consts.vh
// constants for the speech pre/post filter datapath
`ifndef SPPF_CONSTS_VH
`define SPPF_CONSTS_VH
`define SPPF_MAX16      16'sh7fff
`define SPPF_MIN16      16'sh8000
`define SPPF_MAX32      32'sh7fffffff
`define SPPF_MIN32      32'sh80000000
`define SPPF_RND15      32'sh00004000
`define SPPF_FRAC_SH    15
`define SPPF_HP_COEF    16'sh7fdf
`define SPPF_PRE_COEF   16'sh91ec
`define SPPF_DE_COEF    16'sh6e14
`define SPPF_DS_RSH     3
`define SPPF_DS_LSH     2
`define SPPF_DS_DOWN    5'h1d   // minus three: right shift by three
`define SPPF_DS_UP      5'h02   // plus two: left shift by two
`define SPPF_FRAC_UP    6'h0f   // plus fifteen: into the accumulator
`define SPPF_FRAC_DN    6'h31   // minus fifteen: high part of state
`define SPPF_FRAME_LEN  8'ha0
`define SPPF_SUB_LEN    6'h28
`define SPPF_SUB_CNT    3'h4
`endif

//--- sppf_asserts.sv
// port assertions for the speech pre/post filter datapath
`timescale 1ns/1ps
`default_nettype none
module sppf_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        pre_valid,
  input wire logic        pre_ready,
  input wire logic [15:0] pre_sample,
  input wire logic        pre_frame_start,
  input wire logic        pre_sub_start,
  input wire logic        dec_valid,
  input wire logic        dec_ready,
  input wire logic        deemph_valid,
  input wire logic        deemph_ready,
  input wire logic [15:0] deemph_output,
  input wire logic [15:0] norm_in,
  input wire logic [5:0]  norm_count,
  input wire logic [15:0] div_num,
  input wire logic [15:0] div_den,
  input wire logic [15:0] div_quot
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] norm_q;  // operand behind the current count
  wire  [15:0] norm_sh = norm_q << norm_count;  // normalised operand
  // follows the one-cycle latency of the normaliser
  always @(posedge clk or negedge resetn) begin
    if (!resetn) norm_q <= 16'h0;
    else norm_q <= norm_in;
  end
  pre_hold_a: assert property (pre_valid && !pre_ready |=>
    pre_valid && $stable(pre_sample)) else $error("pre sample dropped");
  sub_hold_a: assert property (pre_valid && !pre_ready |=>
    $stable(pre_sub_start) && $stable(pre_frame_start))
    else $error("segment flag moved in stall");
  frame_sub_a: assert property (pre_frame_start |->
    pre_sub_start && pre_valid) else $error("frame start off segment");
  dec_gap_a: assert property (dec_valid && dec_ready |=>
    !dec_ready && deemph_valid) else $error("decoder accept wrong");
  deemph_hold_a: assert property (deemph_valid && !deemph_ready |=>
    deemph_valid && $stable(deemph_output)) else $error("deemph dropped");
  div_eq_a: assert property (div_num == div_den && div_num != 16'h0 &&
    !div_num[15] |=> div_quot == 16'h7fff) else $error("div equal wrong");
  div_half_a: assert property (div_num != 16'h0 && !div_num[15:14] &&
    div_den == div_num << 1 |=> div_quot == 16'h4000)
    else $error("div half wrong");
  norm_zero_a: assert property (norm_in == 16'h0 |=>
    norm_count == 6'h0) else $error("norm of zero wrong");
  norm_ok_a: assert property (norm_in != 16'h0 |=>
    norm_sh[15] != norm_sh[14] || norm_sh == 16'hc000)
    else $error("norm count wrong");
endmodule // sppf_asserts
bind sppf_filter sppf_asserts sppf_asserts_i (.clk(clk), .resetn(resetn),
  .pre_valid(pre_valid), .pre_ready(pre_ready), .pre_sample(pre_sample),
  .pre_frame_start(pre_frame_start), .pre_sub_start(pre_sub_start),
  .dec_valid(dec_valid), .dec_ready(dec_ready),
  .deemph_valid(deemph_valid), .deemph_ready(deemph_ready),
  .deemph_output(deemph_output), .norm_in(norm_in),
  .norm_count(norm_count), .div_num(div_num), .div_den(div_den),
  .div_quot(div_quot));
`default_nettype wire

//--- sppf_src.sv
// sample source model feeding the encoder side
`timescale 1ns/1ps
`default_nettype none
module sppf_src (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        go,
  input  wire logic [15:0] count,
  input  wire logic        enc_ready,
  output var  logic        enc_valid,
  output var  logic [15:0] enc_sample,
  output var  logic        busy
);
  logic [15:0] k;     // word index
  logic        took;  // last edge accepted a word
  logic        gap;   // one idle slot to act as a slow source
  always @(posedge clk) took <= enc_valid && enc_ready;
  // low three bits carry junk so the sink must ignore them
  always @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      k = 16'h0;
      busy = 1'b0;
      gap = 1'b0;
      enc_valid = 1'b0;
      enc_sample = 16'h5a5a;
    end else begin
      if (go) busy = 1'b1;
      if (took) k = k + 16'h1;
      if (k == count) busy = 1'b0;
      gap = took && k[1:0] == 2'h3;
      enc_valid = busy && !gap;
      // idle line toggles so a stale word is never mistaken for data
      if (!enc_valid) enc_sample = ~enc_sample;
      else if (k < 16'h6) enc_sample = k[0] ? 16'h8003 : 16'h7ffd;
      else enc_sample = k * 16'h3a5b;
    end
  end
endmodule // sppf_src
`default_nettype wire

//--- tb_top.sv
// testbench for the speech pre/post filter datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, resetn, go, pre_ready, dec_valid, deemph_ready;
  logic [15:0] nsend, dec_sample, norm_in, div_num, div_den;
  wire         enc_valid, enc_ready, busy, pre_valid, dec_ready;
  wire         pre_frame_start, pre_sub_start, deemph_valid;
  wire  [15:0] enc_sample, pre_sample, deemph_output, div_quot;
  wire  [5:0]  norm_count;
  int          err_total, cmp_count, oidx;
  logic        [15:0] eq[$], dq[$];              // expected outputs
  logic signed [15:0] mp, z1, dp;                // model state
  logic signed [31:0] z2;                        // high-pass state
  sppf_filter sppf_filter_i (.clk(clk), .resetn(resetn),
    .enc_valid(enc_valid), .enc_sample(enc_sample), .enc_ready(enc_ready),
    .pre_valid(pre_valid), .pre_sample(pre_sample),
    .pre_frame_start(pre_frame_start), .pre_sub_start(pre_sub_start),
    .pre_ready(pre_ready), .dec_valid(dec_valid), .dec_sample(dec_sample),
    .dec_ready(dec_ready), .deemph_valid(deemph_valid),
    .deemph_output(deemph_output), .deemph_ready(deemph_ready),
    .norm_in(norm_in), .norm_count(norm_count), .div_num(div_num),
    .div_den(div_den), .div_quot(div_quot));
  sppf_src sppf_src_i (.clk(clk), .resetn(resetn), .go(go), .count(nsend),
    .enc_ready(enc_ready), .enc_valid(enc_valid), .enc_sample(enc_sample),
    .busy(busy));
  function automatic logic signed [15:0] sat(longint v);
    return v > 32767 ? 16'sh7fff : v < -32768 ? 16'sh8000 : v[15:0];
  endfunction
  function automatic logic signed [15:0] mr(longint a, longint b);
    return a == -32768 && b == -32768 ? 16'sh7fff : 16'((a*b+16384)>>>15);
  endfunction
  function automatic logic signed [31:0] la(longint v);
    return v > 2147483647 ? 32'sh7fffffff :
      v < -64'sd2147483648 ? 32'sh80000000 : v[31:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reference of downscale, offset filter and pre-emphasis
  task automatic hp(input logic signed [15:0] s);
    logic signed [15:0] so, msp, sof;
    logic signed [31:0] s2;
    so = (s >>> 3) <<< 2;
    s2 = sat(so - z1) <<< 15;
    z1 = so;
    msp = z2 >>> 15;
    s2 = la(s2 + mr(z2 - (msp <<< 15), 32735));
    z2 = la(msp * 32735 + s2);
    sof = la(z2 + 16384) >>> 15;
    eq.push_back(sat(sof + mr(mp, -28180)));
    mp = sof;
  endtask
  // model follows accepted words; outputs judged on handshake
  always @(posedge clk) begin
    if (!resetn) begin
      {mp, z1, dp, z2, oidx} = '0;
      eq.delete();
      dq.delete();
    end else begin
      if (enc_valid && enc_ready) hp(enc_sample);
      if (dec_valid && dec_ready) begin
        dp = sat($signed(dec_sample) + mr(dp, 28180));
        dq.push_back(dp);
      end
      if (pre_valid && pre_ready) begin
        chk("pre_sample", pre_sample, eq.pop_front());
        chk("frame_start", pre_frame_start, oidx % 160 == 0);
        chk("sub_start", pre_sub_start, oidx % 40 == 0);
        oidx++;
      end
      if (deemph_valid && deemph_ready)
        chk("deemph", deemph_output, dq.pop_front());
    end
  end
  // normaliser and divider boundary cases
  task automatic t_prim();
    logic [15:0] nv[6] = '{16'h0001, 16'hffff, 16'h4000, 16'h0, 16'h8000,
                           16'hc000};
    logic [5:0]  ne[6] = '{6'he, 6'hf, 6'h0, 6'h0, 6'h0, 6'h0};
    logic [15:0] dn[4] = '{16'h1, 16'h5, 16'h1, 16'h3};
    logic [15:0] dd[4] = '{16'h2, 16'h5, 16'h7fff, 16'h4};
    logic [15:0] dq_e[4] = '{16'h4000, 16'h7fff, 16'h1, 16'h6000};
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      norm_in = nv[i];
      div_num = dn[i % 4];
      div_den = dd[i % 4];
      @(negedge clk);
      chk("norm", norm_count, ne[i]);
      chk("div", div_quot, dq_e[i % 4]);
    end
  endtask
  // source fills the buffer, then sink stalls every third cycle
  task automatic t_enc(input logic [15:0] n);
    int c;
    pre_ready = 1'b0;
    nsend <= n;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (6) @(negedge clk);
    chk("enc_ready", enc_ready, 1'b0);
    for (c = 0; c < 4000 && (busy || eq.size() > 0); c++) begin
      pre_ready = c % 3 != 1;
      @(negedge clk);
    end
    if (c == 4000) begin
      err_total++;
      final_report();
    end
    chk("enc_count", oidx, n);
  endtask
  // decoder words pushed into saturation while the sink stalls
  task automatic t_dec();
    int c, w;
    for (c = 0; c < 40; c++) begin
      dec_valid = 1'b1;
      dec_sample = c < 12 ? 16'h7fff : 16'h9000 + c * 16'h0777;
      deemph_ready = c % 4 != 3;
      for (w = 0; w < 20 && !dec_ready; w++) begin
        @(negedge clk);
        if (w == 1) deemph_ready = 1'b1;  // end the sink stall
      end
      if (w == 20) begin
        err_total++;
        final_report();
      end
      @(negedge clk);
    end
    dec_valid = 1'b0;
    deemph_ready = 1'b1;
    for (c = 0; c < 20 && dq.size() > 0; c++) @(negedge clk);
    chk("deemph_left", dq.size(), 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {resetn, go, pre_ready, dec_valid, deemph_ready} = '0;
    {nsend, dec_sample, norm_in, div_num, div_den} = '0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    t_prim();
    t_enc(16'd164);
    t_dec();
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    t_enc(16'd45);
    t_dec();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
